// *** sfd_pkg.sv ***
`default_nettype none
package sfd_pkg;
    // ****************************************
    // command opcodes
    // ****************************************
    localparam logic [7:0] SFD_OP_DUAL_READ = 8'h3b;
    localparam logic [7:0] SFD_OP_PROGRAM = 8'h02;
    localparam logic [7:0] SFD_OP_DUAL_PROGRAM = 8'ha2;
    localparam logic [7:0] SFD_OP_READ_STATUS = 8'h05;
    localparam logic [7:0] SFD_OP_ACTIVE_STATUS = 8'h25;
    localparam logic [7:0] SFD_OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] SFD_OP_WRITE_DISABLE = 8'h04;

    // ****************************************
    // framing and array layout
    // ****************************************
    localparam int SFD_ADDR_BYTES = 3;
    localparam logic [1:0] SFD_LAST_ADDR_BYTE = 2'h2;
    localparam logic [2:0] SFD_LAST_BIT = 3'h7;
    localparam logic [2:0] SFD_LAST_DUAL_BIT = 3'h6;
    localparam logic [1:0] SFD_LAST_PAIR = 2'h3;
    localparam logic [7:0] SFD_ERASED = 8'hff;

    // ****************************************
    // status byte field positions
    // ****************************************
    localparam int SFD_ST_BUSY = 0;
    localparam int SFD_ST_WEL = 1;
    localparam int SFD_ST_EPE = 5;

    // ****************************************
    // timing
    // ****************************************
    localparam int SFD_CLK_PERIOD_NS = 5;

    typedef enum logic [7:0] {
        SFD_CMD_OPC = 8'h01,
        SFD_CMD_ADDR = 8'h02,
        SFD_CMD_DUMMY = 8'h04,
        SFD_CMD_RDATA = 8'h08,
        SFD_CMD_PDATA = 8'h10,
        SFD_CMD_STAT = 8'h20,
        SFD_CMD_ASI = 8'h40,
        SFD_CMD_SKIP = 8'h80
    } sfd_cmd_t;

    typedef enum logic [2:0] {
        SFD_PG_IDLE = 3'h1,
        SFD_PG_WRITE = 3'h2,
        SFD_PG_WAIT = 3'h4
    } sfd_pg_t;
endpackage
`default_nettype wire

// *** sfd_flash.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfd_flash
    import sfd_pkg::*;
#(
    parameter int ADDR_W = 18,
    parameter int SECT_W = 16,
    parameter int NSECT = 4,
    parameter int PAGE_PROGRAM_TIME_NS = 20000,
    parameter int BYTE_PROGRAM_TIME_NS = 2000
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_second_data_pin,
    input wire logic i_so,
    input wire logic [NSECT-1:0] i_sector_protected,
    output logic o_so,
    output logic o_so_oe,
    output logic o_second_data_pin,
    output logic o_second_data_pin_oe,
    output logic o_busy,
    output logic o_write_enable_latch,
    output logic o_erase_program_error_flag
);
    localparam int PAGE_CYC = PAGE_PROGRAM_TIME_NS / SFD_CLK_PERIOD_NS;
    localparam int BYTE_CYC = BYTE_PROGRAM_TIME_NS / SFD_CLK_PERIOD_NS;
    localparam int PAGE_BYTES = 256;
    localparam int CNT_W = $clog2(PAGE_CYC + 1);

    // ****************************************
    // pin synchronisers and edge detection
    // ****************************************
    logic [2:0] cs_sy_r;
    logic [2:0] sck_sy_r;
    logic [1:0] si_sy_r;
    logic [1:0] so_sy_r;
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cs_sy_r <= 3'h7;
            sck_sy_r <= 3'h0;
            si_sy_r <= 2'h0;
            so_sy_r <= 2'h0;
        end else begin
            cs_sy_r <= {cs_sy_r[1:0], i_cs_n};
            sck_sy_r <= {sck_sy_r[1:0], i_sck};
            si_sy_r <= {si_sy_r[0], i_second_data_pin};
            so_sy_r <= {so_sy_r[0], i_so};
        end
    end
    wire cs_high = cs_sy_r[1];
    wire cs_rise = cs_sy_r[1] & ~cs_sy_r[2];
    wire sck_rise = ~cs_high & sck_sy_r[1] & ~sck_sy_r[2];
    wire sck_fall = ~cs_high & ~sck_sy_r[1] & sck_sy_r[2];
    wire si_bit = si_sy_r[1];
    wire so_bit = so_sy_r[1];

    // ****************************************
    // storage
    // ****************************************
    // array held inverted so that its power up zeros read as erased bytes
    bit [7:0] mem_inv [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:PAGE_BYTES-1];

    sfd_cmd_t cmd_r;
    sfd_pg_t pg_r;
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    logic [1:0] byte_r;
    logic [23:0] addr_r;
    logic is_read_r, is_dual_r, is_prog_r, op_wren_r, op_wrdi_r;
    logic [7:0] rd_sh_r;
    logic [1:0] pair_r;
    logic [2:0] fcnt_r;
    logic [ADDR_W-1:0] rd_addr_r;
    logic [ADDR_W-1:0] pstart_r;
    logic [7:0] pidx_r;
    logic [8:0] nbytes_r;
    logic [PAGE_BYTES-1:0] written_r;
    logic [7:0] pg_idx_r;
    logic [CNT_W-1:0] wait_r;
    logic asi_on_r;
    logic busy_r, wel_r, epe_r;
    logic so_r, so_oe_r, sio_r, sio_oe_r;

    // ****************************************
    // decode
    // ****************************************
    wire [7:0] byte_in = {sh_r[6:0], si_bit};
    wire [7:0] dual_in = {sh_r[5:0], so_bit, si_bit};
    wire single_done = sck_rise && bit_r == SFD_LAST_BIT;
    wire dual_done = sck_rise && bit_r == SFD_LAST_DUAL_BIT;
    wire pbyte_done = (cmd_r == SFD_CMD_PDATA) && (is_dual_r ? dual_done : single_done);
    wire [7:0] pbyte = is_dual_r ? dual_in : byte_in;
    wire [23:0] addr_full = {addr_r[15:0], byte_in};
    wire [ADDR_W-1:0] addr_cut = addr_full[ADDR_W-1:0];
    wire [ADDR_W-SECT_W-1:0] sect_idx = pstart_r[ADDR_W-1:SECT_W];
    wire prot_hit = i_sector_protected[sect_idx];
    wire aligned = (cmd_r == SFD_CMD_PDATA) && bit_r == 3'h0 && nbytes_r != 9'h0;
    wire prog_ok = aligned && wel_r && !prot_hit;
    wire prog_start = cs_rise && is_prog_r && prog_ok;
    wire [7:0] status_w = 8'(({7'h0, busy_r} << SFD_ST_BUSY) | ({7'h0, wel_r} << SFD_ST_WEL)
        | ({7'h0, epe_r} << SFD_ST_EPE));
    wire [ADDR_W-1:0] pg_addr = {pstart_r[ADDR_W-1:8], pg_idx_r};
    wire [7:0] pg_merge = ~mem_inv[pg_addr] & pbuf[pg_idx_r];
    wire pg_fail = pg_merge != pbuf[pg_idx_r];
    wire pg_hit = (pg_r == SFD_PG_WRITE) && written_r[pg_idx_r];

    // ****************************************
    // command sequencer on the serial clock
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn || cs_high) begin
            cmd_r <= SFD_CMD_OPC;
            sh_r <= 8'h0;
            bit_r <= 3'h0;
            byte_r <= 2'h0;
            fcnt_r <= 3'h0;
            pair_r <= 2'h0;
            asi_on_r <= 1'b0;
        end else if (sck_rise) begin
            sh_r <= byte_in;
            bit_r <= bit_r + 3'h1;
            unique case (cmd_r)
                SFD_CMD_OPC: begin
                    if (bit_r == SFD_LAST_BIT) begin
                        // status bits count from the first fall after the opcode
                        fcnt_r <= 3'h0;
                        if (byte_in == SFD_OP_READ_STATUS) begin
                            cmd_r <= SFD_CMD_STAT;
                        end else if (byte_in == SFD_OP_ACTIVE_STATUS) begin
                            cmd_r <= SFD_CMD_ASI;
                        end else if (!busy_r && (byte_in == SFD_OP_DUAL_READ
                            || byte_in == SFD_OP_PROGRAM || byte_in == SFD_OP_DUAL_PROGRAM)) begin
                            cmd_r <= SFD_CMD_ADDR;
                        end else begin
                            cmd_r <= SFD_CMD_SKIP;
                        end
                    end
                end
                SFD_CMD_ADDR: begin
                    if (bit_r == SFD_LAST_BIT) begin
                        byte_r <= byte_r + 2'h1;
                        if (byte_r == SFD_LAST_ADDR_BYTE) begin
                            cmd_r <= is_read_r ? SFD_CMD_DUMMY : SFD_CMD_PDATA;
                        end
                    end
                end
                SFD_CMD_DUMMY: begin
                    if (bit_r == SFD_LAST_BIT) begin
                        cmd_r <= SFD_CMD_RDATA;
                    end
                end
                SFD_CMD_PDATA: begin
                    if (is_dual_r) begin
                        sh_r <= dual_in;
                        bit_r <= bit_r + 3'h2;
                    end
                end
                SFD_CMD_ASI: begin
                    if (bit_r == SFD_LAST_BIT) begin
                        asi_on_r <= 1'b1;
                    end
                end
                SFD_CMD_RDATA, SFD_CMD_STAT, SFD_CMD_SKIP: begin
                end
            endcase
        end else if (sck_fall) begin
            fcnt_r <= fcnt_r + 3'h1;
            if (cmd_r == SFD_CMD_RDATA) begin
                pair_r <= pair_r + 2'h1;
            end
        end
    end

    // ****************************************
    // command attributes, address and read path
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            is_read_r <= 1'b0;
            is_dual_r <= 1'b0;
            is_prog_r <= 1'b0;
            op_wren_r <= 1'b0;
            op_wrdi_r <= 1'b0;
            addr_r <= 24'h0;
            rd_addr_r <= '0;
            rd_sh_r <= 8'h0;
            pstart_r <= '0;
        end else if (cs_high) begin
            is_prog_r <= 1'b0;
            op_wren_r <= 1'b0;
            op_wrdi_r <= 1'b0;
        end else if (sck_rise) begin
            if (cmd_r == SFD_CMD_OPC && bit_r == SFD_LAST_BIT) begin
                is_read_r <= byte_in == SFD_OP_DUAL_READ;
                is_dual_r <= byte_in == SFD_OP_DUAL_PROGRAM;
                is_prog_r <= !busy_r && (byte_in == SFD_OP_PROGRAM
                    || byte_in == SFD_OP_DUAL_PROGRAM);
                op_wren_r <= !busy_r && byte_in == SFD_OP_WRITE_ENABLE;
                op_wrdi_r <= !busy_r && byte_in == SFD_OP_WRITE_DISABLE;
            end else if (cmd_r != SFD_CMD_OPC) begin
                op_wren_r <= 1'b0;
                op_wrdi_r <= 1'b0;
            end
            if (cmd_r == SFD_CMD_ADDR && bit_r == SFD_LAST_BIT) begin
                addr_r <= addr_full;
                if (byte_r == SFD_LAST_ADDR_BYTE) begin
                    rd_addr_r <= addr_cut;
                    pstart_r <= addr_cut;
                end
            end
            if (cmd_r == SFD_CMD_DUMMY && bit_r == SFD_LAST_BIT) begin
                rd_sh_r <= ~mem_inv[rd_addr_r];
                rd_addr_r <= rd_addr_r + 1'b1;
            end
        end else if (sck_fall && cmd_r == SFD_CMD_RDATA) begin
            if (pair_r == SFD_LAST_PAIR) begin
                rd_sh_r <= ~mem_inv[rd_addr_r];
                rd_addr_r <= rd_addr_r + 1'b1;
            end else begin
                rd_sh_r <= {rd_sh_r[5:0], 2'h0};
            end
        end
    end

    // ****************************************
    // page buffer capture
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pidx_r <= 8'h0;
            nbytes_r <= 9'h0;
            written_r <= '0;
        end else if (sck_rise && cmd_r == SFD_CMD_ADDR && bit_r == SFD_LAST_BIT
            && byte_r == SFD_LAST_ADDR_BYTE && is_prog_r) begin
            pidx_r <= byte_in;
            nbytes_r <= 9'h0;
            written_r <= '0;
        end else if (pbyte_done) begin
            pidx_r <= pidx_r + 8'h1;
            written_r[pidx_r] <= 1'b1;
            if (nbytes_r != 9'(PAGE_BYTES)) begin
                nbytes_r <= nbytes_r + 9'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (pbyte_done) begin
            pbuf[pidx_r] <= pbyte;
        end
    end

    // ****************************************
    // self timed program engine
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pg_r <= SFD_PG_IDLE;
            pg_idx_r <= 8'h0;
            wait_r <= '0;
            busy_r <= 1'b0;
            epe_r <= 1'b0;
        end else begin
            unique case (pg_r)
                SFD_PG_IDLE: begin
                    if (prog_start) begin
                        pg_r <= SFD_PG_WRITE;
                        pg_idx_r <= 8'h0;
                        busy_r <= 1'b1;
                        epe_r <= 1'b0;
                        wait_r <= (nbytes_r == 9'h1) ? CNT_W'(BYTE_CYC) : CNT_W'(PAGE_CYC);
                    end
                end
                SFD_PG_WRITE: begin
                    pg_idx_r <= pg_idx_r + 8'h1;
                    if (pg_hit && pg_fail) begin
                        epe_r <= 1'b1;
                    end
                    if (pg_idx_r == 8'(PAGE_BYTES - 1)) begin
                        pg_r <= SFD_PG_WAIT;
                    end
                end
                SFD_PG_WAIT: begin
                    wait_r <= wait_r - 1'b1;
                    if (wait_r <= CNT_W'(PAGE_BYTES + 1)) begin
                        pg_r <= SFD_PG_IDLE;
                        busy_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (pg_hit) begin
            mem_inv[pg_addr] <= ~pg_merge;
        end
    end

    // ****************************************
    // write enable latch
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wel_r <= 1'b0;
        end else if (cs_rise && is_prog_r) begin
            wel_r <= 1'b0;
        end else if (cs_rise && bit_r == 3'h0 && op_wrdi_r) begin
            wel_r <= 1'b0;
        end else if (cs_rise && bit_r == 3'h0 && op_wren_r) begin
            wel_r <= 1'b1;
        end
    end

    // ****************************************
    // output drivers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn || cs_high) begin
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
            sio_r <= 1'b0;
            sio_oe_r <= 1'b0;
        end else if (asi_on_r) begin
            so_r <= busy_r;
            so_oe_r <= 1'b1;
        end else if (sck_fall && cmd_r == SFD_CMD_RDATA) begin
            so_r <= rd_sh_r[7];
            sio_r <= rd_sh_r[6];
            so_oe_r <= 1'b1;
            sio_oe_r <= 1'b1;
        end else if (sck_fall && cmd_r == SFD_CMD_STAT) begin
            so_r <= status_w[SFD_LAST_BIT - fcnt_r];
            so_oe_r <= 1'b1;
        end
    end

    assign o_so = so_r;
    assign o_so_oe = so_oe_r;
    assign o_second_data_pin = sio_r;
    assign o_second_data_pin_oe = sio_oe_r;
    assign o_busy = busy_r;
    assign o_write_enable_latch = wel_r;
    assign o_erase_program_error_flag = epe_r;

    // ****************************************
    // checks
    // ****************************************
    logic [CNT_W:0] busy_cnt_r;
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !busy_r) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
        end
    end

    property p_release;
        @(posedge i_clk) disable iff (!i_resetn)
        cs_high |=> !o_so_oe && !o_second_data_pin_oe;
    endproperty
    a_release: assert property (p_release) else $error("pins not released");

    property p_pair;
        @(posedge i_clk) disable iff (!i_resetn)
        sck_fall && cmd_r == SFD_CMD_RDATA && !asi_on_r |=> o_so_oe && o_second_data_pin_oe
            && o_so == $past(rd_sh_r[7]) && o_second_data_pin == $past(rd_sh_r[6]);
    endproperty
    a_pair: assert property (p_pair) else $error("dual read bit pair wrong");

    property p_wrap;
        @(posedge i_clk) disable iff (!i_resetn)
        sck_fall && cmd_r == SFD_CMD_RDATA && pair_r == SFD_LAST_PAIR && (&rd_addr_r)
            |=> rd_addr_r == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("read did not wrap");

    property p_dummy;
        @(posedge i_clk) disable iff (!i_resetn)
        $rose(cmd_r == SFD_CMD_RDATA) |-> $past(cmd_r) == SFD_CMD_DUMMY;
    endproperty
    a_dummy: assert property (p_dummy) else $error("read data before dummy");

    property p_abort;
        @(posedge i_clk) disable iff (!i_resetn)
        cs_rise && is_prog_r && !aligned |=> !wel_r ##1 !busy_r;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not handled");

    property p_protect;
        @(posedge i_clk) disable iff (!i_resetn)
        cs_rise && is_prog_r && prot_hit && !busy_r |=> !busy_r && !wel_r;
    endproperty
    a_protect: assert property (p_protect) else $error("protected target programmed");

    property p_start;
        @(posedge i_clk) disable iff (!i_resetn)
        prog_start |=> busy_r && !wel_r && pg_r == SFD_PG_WRITE;
    endproperty
    a_start: assert property (p_start) else $error("program did not start");

    property p_bound;
        @(posedge i_clk) disable iff (!i_resetn)
        busy_r |-> busy_cnt_r <= (CNT_W+1)'(PAGE_CYC + 2);
    endproperty
    a_bound: assert property (p_bound) else $error("program cycle too long");

    property p_asi;
        @(posedge i_clk) disable iff (!i_resetn)
        asi_on_r && !cs_high |=> o_so_oe && o_so == $past(busy_r);
    endproperty
    a_asi: assert property (p_asi) else $error("active status wrong");

    property p_busybit;
        @(posedge i_clk) disable iff (!i_resetn)
        sck_fall && cmd_r == SFD_CMD_STAT && fcnt_r == SFD_LAST_BIT |=> o_so == $past(busy_r);
    endproperty
    a_busybit: assert property (p_busybit) else $error("status busy bit wrong");

    property p_error;
        @(posedge i_clk) disable iff (!i_resetn)
        pg_hit && pg_fail |=> epe_r [*2];
    endproperty
    a_error: assert property (p_error) else $error("program error not flagged");
endmodule
`default_nettype wire

// *** sfd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfd_host (
    input wire logic i_clk,
    input wire logic i_so_w,
    input wire logic i_sio_w,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    output logic o_si_en,
    output logic o_so,
    output logic o_so_en
);
    // ****************************************
    // host side of the serial link
    // ****************************************
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_si_en = 1'b0;
        o_so = 1'b0;
        o_so_en = 1'b0;
    end

    task automatic open_frame();
        @(negedge i_clk);
        o_cs_n = 1'b0;
    endtask

    // leaves at least 8 clocks of deselect before the next frame
    task automatic close_frame();
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_si_en = 1'b0;
        o_so_en = 1'b0;
        repeat (8) @(negedge i_clk);
    endtask

    // one byte, msb first; dual moves pairs with the high bit on so
    task automatic xfer(input logic [7:0] b, input bit dual, input bit rd,
                        output logic [7:0] r);
        int n;
        n = dual ? 4 : 8;
        o_si_en = !rd;
        o_so_en = dual && !rd;
        for (int i = 0; i < n; i++) begin
            if (dual) begin
                o_so = b[7-2*i];
                o_si = b[6-2*i];
            end else begin
                o_si = b[7-i];
            end
            #32 o_sck = 1'b1;
            if (dual) begin
                r[7-2*i] = i_so_w;
                r[6-2*i] = i_sio_w;
            end else begin
                r[7-i] = i_so_w;
            end
            #32 o_sck = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** tb_spi_flash_dual_read_program.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %0t %s", $time, m); end end
module tb_spi_flash_dual_read_program;
    import sfd_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] prot = 4'h0;
    logic cs_n, sck, si, si_en, so, so_en, so_w, sio_w;
    logic o_so, o_so_oe, o_sio, o_sio_oe, o_busy, o_wel, o_epe;
    logic [7:0] r;
    logic [7:0] rbuf [0:3];
    int failures = 0;
    int n_compared = 0;
    always #2.5 i_clk = ~i_clk;
    // a released line shows the inverse of what was last put on it
    assign so_w = o_so_oe ? o_so : (so_en ? so : ~so);
    assign sio_w = o_sio_oe ? o_sio : (si_en ? si : ~si);
    sfd_host host (.i_clk(i_clk), .i_so_w(so_w), .i_sio_w(sio_w), .o_cs_n(cs_n),
        .o_sck(sck), .o_si(si), .o_si_en(si_en), .o_so(so), .o_so_en(so_en));
    sfd_flash #(.PAGE_PROGRAM_TIME_NS(2000), .BYTE_PROGRAM_TIME_NS(1400)) dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sck(sck),
        .i_second_data_pin(sio_w), .i_so(so_w), .i_sector_protected(prot),
        .o_so(o_so), .o_so_oe(o_so_oe), .o_second_data_pin(o_sio),
        .o_second_data_pin_oe(o_sio_oe), .o_busy(o_busy), .o_write_enable_latch(o_wel),
        .o_erase_program_error_flag(o_epe));
    // ****************************************
    // access tasks
    // ****************************************
    task automatic op(input logic [7:0] c);
        host.open_frame();
        host.xfer(c, 1'b0, 1'b0, r);
    endtask
    task automatic addr(input logic [23:0] a);
        for (int i = 2; i >= 0; i--) host.xfer(a[8*i+:8], 1'b0, 1'b0, r);
    endtask
    task automatic status(output logic [7:0] s);
        op(SFD_OP_READ_STATUS);
        host.xfer(8'h00, 1'b0, 1'b1, s);
        host.close_frame();
    endtask
    task automatic wait_idle();
        logic [7:0] s;
        status(s);
        `CHK(s[SFD_ST_BUSY], 1'b1, "busy bit")
        `CHK(s[SFD_ST_WEL], 1'b0, "latch in cycle")
        for (int i = 0; i < 60 && s[SFD_ST_BUSY] !== 1'b0; i++) status(s);
        `CHK(s[SFD_ST_BUSY], 1'b0, "busy end")
    endtask
    // byte k carries base + k, plus 40h once past the first 256
    task automatic prog(input logic [7:0] c, input logic [23:0] a, input bit dual,
                        input int n, input logic [7:0] base);
        op(SFD_OP_WRITE_ENABLE);
        host.close_frame();
        op(c);
        addr(a);
        for (int k = 0; k < n; k++) host.xfer(base + 8'(k) + (k > 255 ? 8'h40 : 8'h00),
            dual, 1'b0, r);
        host.close_frame();
    endtask
    task automatic rd(input logic [23:0] a, input int n);
        op(SFD_OP_DUAL_READ);
        addr(a);
        host.xfer(8'h00, 1'b0, 1'b0, r);
        for (int k = 0; k < n; k++) host.xfer(8'h00, 1'b1, 1'b1, rbuf[k]);
        host.close_frame();
        `CHK({o_so_oe, o_sio_oe}, 2'h0, "pins released")
    endtask
    task automatic report_and_stop();
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clk);
        `CHK({o_busy, o_wel, o_so_oe, o_sio_oe}, 4'h0, "reset state")
        prog(SFD_OP_PROGRAM, 24'hfc00fe, 1'b0, 3, 8'h10);
        wait_idle();
        rd(24'h0000fe, 4);
        `CHK({rbuf[0], rbuf[1], rbuf[2], rbuf[3]}, 32'h1011ffff, "page wrap")
        rd(24'h03fffe, 3);
        `CHK({rbuf[0], rbuf[1], rbuf[2]}, 24'hffff12, "array wrap")
        prog(SFD_OP_DUAL_PROGRAM, 24'h000100, 1'b1, 1, 8'h5a);
        wait_idle();
        rd(24'h000100, 1);
        `CHK(rbuf[0], 8'h5a, "dual program")
        prog(SFD_OP_PROGRAM, 24'h000100, 1'b0, 1, 8'ha5);
        wait_idle();
        `CHK(o_epe, 1'b1, "error flag")
        prog(SFD_OP_PROGRAM, 24'h000200, 1'b0, 257, 8'h03);
        wait_idle();
        rd(24'h000200, 2);
        `CHK({rbuf[0], rbuf[1]}, 16'h4304, "last 256 kept")
        // past the address a dual transfer gives four clocks, half a byte
        for (int i = 1; i <= 5; i++) begin
            op(SFD_OP_WRITE_ENABLE);
            host.close_frame();
            op(SFD_OP_PROGRAM);
            for (int j = 0; j < i; j++) host.xfer(8'h00, j > 2 && j == i - 1, 1'b0, r);
            host.close_frame();
            `CHK({o_busy, o_wel}, 2'h0, "short program")
        end
        @(negedge i_clk);
        prot = 4'h1;
        prog(SFD_OP_PROGRAM, 24'h000400, 1'b0, 1, 8'h00);
        `CHK({o_busy, o_wel}, 2'h0, "protected")
        @(negedge i_clk);
        prot = 4'h0;
        rd(24'h000400, 1);
        `CHK(rbuf[0], SFD_ERASED, "protected untouched")
        prog(SFD_OP_PROGRAM, 24'h000500, 1'b0, 1, 8'h33);
        op(SFD_OP_ACTIVE_STATUS);
        host.xfer(8'h00, 1'b0, 1'b1, r);
        repeat (4) @(negedge i_clk);
        `CHK(so_w, 1'b1, "busy on so")
        for (int i = 0; i < 2000 && o_busy !== 1'b0; i++) @(negedge i_clk);
        repeat (5) @(negedge i_clk);
        `CHK(so_w, 1'b0, "so low at end")
        host.close_frame();
        report_and_stop();
    end
endmodule
`default_nettype wire
